// ===== grab_mode_regs.sv
`timescale 1ns/1ns
`include "grab_ctrl_map.svh"
module grab_mode_regs import grab_ctrl_pkg::*; #(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // axi4-lite write address
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // camera and system inputs
  input  wire logic              frameValid,
  input  wire logic [`PIX_W-1:0] pixelIn,
  input  wire logic              pixelInValid,
  input  wire logic              optoTrigger,
  input  wire logic              shutterExpose,
  input  wire logic              dmaDone,
  // camera control lines
  output logic [3:0]             camCtrl,
  // pixels to host
  output logic [`PIX_W-1:0]      pixelOut,
  output logic                   pixelOutValid,
  // shutter timer side
  output logic [1:0]             shutterUnitSel,
  output logic                   unitTick,
  output logic                   acquiring
);
  reg8_t             path_q;
  reg8_t             cam_q;
  logic              go_q;
  logic              dclrTog_q;
  logic              pend_q;
  logic              fvPrev_q;
  acq_state_e        state_q;
  acq_state_e        state_d;
  logic [3:0]        cc_q;
  logic [3:0]        ccNext;
  logic [`PIX_W-1:0] pix_q;
  logic              pixValid_q;
  logic              acq_q;
  // bus side
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic [7:0]        awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // write decode: fires once both address and data are held
  wire       doWrite  = !awready_q && !wready_q && !bvalid_q;
  wire [5:0] wrIdx    = awAddr_q[7:2];
  wire       wrLane   = doWrite && wStrb_q[0];
  wire [7:0] wrByte   = wData_q[7:0];
  wire       wrHit    = (wrIdx == `IDX_CMD) || (wrIdx == `IDX_PATH) ||
                        (wrIdx == `IDX_CAMCFG) || (wrIdx == `IDX_STAT);
  wire       cmdWr    = wrLane && (wrIdx == `IDX_CMD);
  wire       pathWr   = wrLane && (wrIdx == `IDX_PATH);
  wire       camWr    = wrLane && (wrIdx == `IDX_CAMCFG);
  wire       dclrFlip = cmdWr && (wrByte[`CMD_DCLR] != dclrTog_q);
  wire       goSet    = cmdWr && wrByte[`CMD_GO];
  wire       goClr    = cmdWr && !wrByte[`CMD_GO];

  // read decode
  wire       arFire = arvalid && arready_q;
  wire [5:0] rdIdx  = araddr[7:2];
  wire       rdHit  = (rdIdx == `IDX_CMD) || (rdIdx == `IDX_PATH) ||
                      (rdIdx == `IDX_CAMCFG) || (rdIdx == `IDX_STAT);
  wire [7:0] cmdView  = {4'h0, dclrTog_q, 1'b0, go_q, 1'b0};
  wire [7:0] statView = {5'h00, pend_q, state_q == ACQ_GRAB,
                         state_q != ACQ_IDLE};
  wire [7:0] rdByte = (rdIdx == `IDX_CMD)    ? cmdView :
                      (rdIdx == `IDX_PATH)   ? path_q :
                      (rdIdx == `IDX_CAMCFG) ? cam_q :
                      (rdIdx == `IDX_STAT)   ? statView : 8'h00;

  // acquisition decode
  wire contOn   = path_q[`PATH_CONT];
  wire fullOn   = path_q[`PATH_FULL];
  wire fvRise   = frameValid && !fvPrev_q;
  wire frameEnd = (state_q == ACQ_GRAB) && !frameValid;
  wire inFrame  = (state_q == ACQ_GRAB) || (state_q == ACQ_ARM && fvRise);
  wire grabPix  = inFrame && frameValid && pixelInValid;
  wire exposeIn = shutterExpose && (state_q != ACQ_IDLE);
  wire fvHost   = frameValid && inFrame;
  wire [`PIX_W-1:0] pixSel = fullOn ? pixelIn :
                             {8'h00, pixelIn[`PIX_W-1:`PIX_W-8]};

  assign awready        = awready_q;
  assign wready         = wready_q;
  assign bvalid         = bvalid_q;
  assign bresp          = bresp_q;
  assign arready        = arready_q;
  assign rvalid         = rvalid_q;
  assign rdata          = rdata_q;
  assign rresp          = rresp_q;
  assign camCtrl        = cc_q;
  assign pixelOut       = pix_q;
  assign pixelOutValid  = pixValid_q;
  assign shutterUnitSel = path_q[`PATH_UNIT_HI:`PATH_UNIT_LO];
  assign acquiring      = acq_q;

  unit_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .mclk    (mclk),
    .srst    (srst),
    .unitSel (path_q[`PATH_UNIT_HI:`PATH_UNIT_LO]),
    .tick    (unitTick)
  );

  cc_router u_route (
    .route  (cam_q[7:4]),
    .level  (cam_q[3:0]),
    .expose (exposeIn),
    .opto   (optoTrigger),
    .fvHost (fvHost),
    .cc     (ccNext)
  );

  // frame sequencer; whole frames only, so arming waits for a frame start
  always_comb begin
    state_d = state_q;
    case (state_q)
      ACQ_IDLE: if (go_q) state_d = ACQ_ARM;
      ACQ_ARM: begin
        if (!go_q) state_d = ACQ_IDLE;
        else if (fvRise) state_d = ACQ_GRAB;
      end
      ACQ_GRAB: begin
        // a cleared flag still lets this frame run out
        if (frameEnd) state_d = (contOn && go_q) ? ACQ_ARM : ACQ_IDLE;
      end
      default: state_d = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q  <= ACQ_IDLE;
      fvPrev_q <= 1'b0;
      acq_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      fvPrev_q <= frameValid;
      acq_q    <= (state_d != ACQ_IDLE);
    end
  end

  // go bit: software write wins over the end-of-capture clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      go_q <= 1'b0;
    end else if (goSet || goClr) begin
      go_q <= goSet;
    end else if (frameEnd && state_d == ACQ_IDLE) begin
      go_q <= 1'b0;
    end
  end

  // deferred clear is armed by a change of the toggle bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      dclrTog_q <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      if (dclrFlip) dclrTog_q <= wrByte[`CMD_DCLR];
      if (dclrFlip) pend_q <= 1'b1;
      else if (dmaDone) pend_q <= 1'b0;
    end
  end

  // path config: a host write beats the deferred clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      path_q <= `PATH_RST;
    end else if (pathWr) begin
      path_q <= wrByte & `PATH_WMASK;
    end else if (pend_q && dmaDone) begin
      path_q[`PATH_CONT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cam_q <= `CAM_RST;
    end else if (camWr) begin
      cam_q <= wrByte;
    end
  end

  // control lines and pixels are registered so outputs never glitch
  always_ff @(posedge mclk) begin
    if (srst) begin
      cc_q       <= 4'h0;
      pix_q      <= '0;
      pixValid_q <= 1'b0;
    end else begin
      cc_q       <= ccNext;
      pixValid_q <= grabPix;
      if (grabPix) pix_q <= pixSel;
    end
  end

  // bus write channels: address and data taken in either order
  always_ff @(posedge mclk) begin
    if (srst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
    end else begin
      if (awvalid && awready_q) begin
        awAddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wData_q  <= wdata;
        wStrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // bus read channels
  always_ff @(posedge mclk) begin
    if (srst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else if (arFire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rdByte};
      rresp_q   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_unit_none;
    path_q[7:6] == 2'h3 |-> ##1 !unitTick;
  endproperty
  a_unit_none: assert property (p_unit_none)
    else $error("tick while unit code reserved");
  property p_cont_next;
    state_q == ACQ_GRAB && !frameValid && contOn && go_q
      |=> state_q == ACQ_ARM;
  endproperty
  a_cont_next: assert property (p_cont_next)
    else $error("continuous capture did not rearm");
  property p_no_go;
    state_q == ACQ_IDLE && !go_q |=> state_q == ACQ_IDLE;
  endproperty
  a_no_go: assert property (p_no_go)
    else $error("capture started without go bit");
  property p_finish;
    state_q == ACQ_GRAB && frameValid |=> state_q == ACQ_GRAB;
  endproperty
  a_finish: assert property (p_finish)
    else $error("frame cut short");
  property p_clear_now;
    pathWr && !wrByte[`PATH_CONT] |=> !contOn;
  endproperty
  a_clear_now: assert property (p_clear_now)
    else $error("continuous not cleared at once");
  property p_defer;
    pend_q && dmaDone && !pathWr && !dclrFlip |=> !contOn && !pend_q;
  endproperty
  a_defer: assert property (p_defer)
    else $error("deferred clear missed dma completion");
  property p_depth;
    grabPix && !fullOn |=> pixelOutValid && pixelOut ==
      {8'h00, $past(pixelIn[`PIX_W-1:`PIX_W-8])};
  endproperty
  a_depth: assert property (p_depth)
    else $error("reduced pixel wrong");
  property p_no_route;
    cam_q[7:4] == 4'h0 && !camWr |=> camCtrl == $past(cam_q[3:0]);
  endproperty
  a_no_route: assert property (p_no_route)
    else $error("expose leaked with empty route");
  property p_opto2;
    cam_q[7:4] == `ROUTE_OPTO2 |=>
      camCtrl == {2'b00, $past(optoTrigger), 1'b0};
  endproperty
  a_opto2: assert property (p_opto2)
    else $error("opto route two wrong");
  property p_fv4;
    cam_q[7:5] == `ROUTE_FV3 && (state_q == ACQ_IDLE || !frameValid ||
      (state_q == ACQ_ARM && fvPrev_q)) |=> !camCtrl[3];
  endproperty
  a_fv4: assert property (p_fv4)
    else $error("frame valid sent for undelivered frame");
  property p_unused;
    (path_q & ~`PATH_WMASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused path bits set");
  c_rearm: cover property (state_q == ACQ_GRAB ##1 state_q == ACQ_ARM);
  c_defer: cover property (pend_q && dmaDone);
  c_opto1: cover property (cam_q[7:4] == `ROUTE_OPTO1 && optoTrigger);
endmodule

// ===== grab_ctrl_map.svh
`ifndef GRAB_CTRL_MAP_SVH
`define GRAB_CTRL_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CMD      6'h00
`define IDX_PATH     6'h06
`define IDX_CAMCFG   6'h07
`define IDX_STAT     6'h08

// acquire path config fields
`define PATH_UNIT_HI 7
`define PATH_UNIT_LO 6
`define PATH_CONT    4
`define PATH_FULL    0
`define PATH_WMASK   8'hD1
`define PATH_RST     8'h00

// command fields
`define CMD_GO       1
`define CMD_DCLR     3
`define CMD_WMASK    8'h0A
`define CMD_RST      8'h00

// camera line drive config
`define CAM_RST      8'h00
`define ROUTE_OPTO1  4'hA
`define ROUTE_OPTO2  4'hB
`define ROUTE_FV3    3'h6

// unit codes
`define UNIT_1MS     2'h0
`define UNIT_10MS    2'h1
`define UNIT_100MS   2'h2

// timing
`define CLK_NS       8
`define MS_NS        1000000
`define CYC_PER_MS   (`MS_NS / `CLK_NS)

`define PIX_W        16
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ===== grab_ctrl_pkg.sv
package grab_ctrl_pkg;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_ARM, ACQ_GRAB} acq_state_e;
  typedef logic [7:0] reg8_t;
endpackage

// ===== unit_tick.sv
`timescale 1ns/1ns
`include "grab_ctrl_map.svh"
module unit_tick import grab_ctrl_pkg::*; #(
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // unit select
  input  wire logic [1:0] unitSel,
  // one pulse per selected unit
  output logic            tick
);
  localparam int MW = $clog2(CYC_PER_MS + 1);

  logic [MW-1:0] msCnt_q;
  logic [6:0]    decCnt_q;
  logic          tick_q;
  logic [6:0]    span;
  wire           msTick = (msCnt_q == MW'(CYC_PER_MS - 1));
  wire           spanEnd = (decCnt_q >= span - 7'd1);

  // reserved code gives no span, hence no tick at all
  assign span = (unitSel == `UNIT_1MS)   ? 7'd1 :
                (unitSel == `UNIT_10MS)  ? 7'd10 :
                (unitSel == `UNIT_100MS) ? 7'd100 : 7'd0;
  assign tick = tick_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      msCnt_q  <= '0;
      decCnt_q <= '0;
      tick_q   <= 1'b0;
    end else begin
      msCnt_q <= msTick ? '0 : msCnt_q + MW'(1);
      tick_q  <= 1'b0;
      if (msTick) begin
        decCnt_q <= spanEnd ? 7'd0 : decCnt_q + 7'd1;
        tick_q   <= spanEnd && (span != 7'd0);
      end
    end
  end
endmodule

// ===== cc_router.sv
`timescale 1ns/1ns
`include "grab_ctrl_map.svh"
module cc_router import grab_ctrl_pkg::*; (
  // configuration
  input  wire logic [3:0] route,
  input  wire logic [3:0] level,
  // sources
  input  wire logic       expose,
  input  wire logic       opto,
  input  wire logic       fvHost,
  // next control line levels
  output logic [3:0]      cc
);
  logic [3:0] plain;

  // per line: routed lines follow expose, others take the static level
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign plain[i] = route[i] ? expose : level[i];
  end

  always_comb begin
    if (route == `ROUTE_OPTO1) begin
      cc = {level[3:1], opto};
    end else if (route == `ROUTE_OPTO2) begin
      cc = {2'b00, opto, 1'b0};
    end else if (route[3:1] == `ROUTE_FV3) begin
      cc = {fvHost, level[2:0]};
    end else begin
      cc = plain;
    end
  end
endmodule

// ===== cam_model.sv
`timescale 1ns/1ns
`include "grab_ctrl_map.svh"
module cam_model #(
  parameter int FLEN = 16
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // frame request from bench
  input  wire logic              trig,
  // camera outputs
  output logic                   frameValid,
  output logic [`PIX_W-1:0]      pixelIn,
  output logic                   pixelInValid
);
  int               cnt;
  logic [15:0]      pat = 16'h1234;

  // pixel bus keeps changing outside frames, so stale data never looks valid
  always @(posedge mclk) begin
    pat <= pat + 16'h3b1d;
    pixelIn <= pat;
    if (srst) begin
      cnt <= 0;
      frameValid <= 1'b0;
      pixelInValid <= 1'b0;
    end else if (cnt == 0) begin
      if (trig) cnt <= 1;
    end else begin
      cnt <= (cnt == FLEN + 4) ? 0 : cnt + 1;
      frameValid <= (cnt >= 2 && cnt < 2 + FLEN);
      pixelInValid <= (cnt >= 2 && cnt < 2 + FLEN);
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ns
`include "grab_ctrl_map.svh"
module tb;
  import grab_ctrl_pkg::*;
  localparam int        fl = 16;
  localparam logic [7:0] aCmd = {`IDX_CMD, 2'b00};
  localparam logic [7:0] aPath = {`IDX_PATH, 2'b00};
  localparam logic [7:0] aCam = {`IDX_CAMCFG, 2'b00};
  localparam logic [7:0] aStat = {`IDX_STAT, 2'b00};
  localparam logic [1:0] ok = `RESP_OKAY;
  logic mclk = 0, srst = 1, trig = 0, fullSel = 0;
  logic [7:0] awaddr = 0, araddr = 0, cfg;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, seed = 32'hdb47, rd, rdata;
  logic [3:0] wstrb = 0, camCtrl;
  logic optoTrigger = 0, shutterExpose = 0, dmaDone = 0;
  logic awready, wready, bvalid, arready, rvalid, frameValid;
  logic pixelInValid, pixelOutValid, unitTick, acquiring;
  logic [1:0] bresp, rresp, shutterUnitSel, rs;
  logic [15:0] pixelIn, pixelOut, prevPix;
  logic [3:0] rtab [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'hB};
  int err_count = 0, n_tests = 0, pixCnt = 0;

  always #4 mclk = ~mclk;

  grab_mode_regs #(.CYC_PER_MS(10)) u_dut (.mclk(mclk), .srst(srst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .frameValid(frameValid), .pixelIn(pixelIn),
    .pixelInValid(pixelInValid), .optoTrigger(optoTrigger),
    .shutterExpose(shutterExpose), .dmaDone(dmaDone), .camCtrl(camCtrl),
    .pixelOut(pixelOut), .pixelOutValid(pixelOutValid),
    .shutterUnitSel(shutterUnitSel), .unitTick(unitTick),
    .acquiring(acquiring));

  cam_model #(.FLEN(fl)) u_cam (.mclk(mclk), .srst(srst), .trig(trig),
    .frameValid(frameValid), .pixelIn(pixelIn),
    .pixelInValid(pixelInValid));

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic to(input bit done);
    if (!done) begin
      chk("wait", 0, 1);
      stop_test;
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [3:0] ccx(input logic [7:0] c, input logic e,
                                     input logic o);
    logic [3:0] v;
    v = c[3:0];
    if (c[7:4] == `ROUTE_OPTO1) v[0] = o;
    else if (c[7:4] == `ROUTE_OPTO2) v = {2'b00, o, 1'b0};
    else for (int i = 0; i < 4; i++) if (c[4+i]) v[i] = e;
    return v;
  endfunction

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    bit dn;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    wvalid <= 1;
    bready <= 1;
    n = 0;
    dn = 0;
    while (!dn && n < 64) begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bready && bvalid) begin
        dn = 1;
        bready <= 0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
      end
    end
    to(dn);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    bit dn;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    n = 0;
    dn = 0;
    while (!dn && n < 64) begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rready && rvalid) begin
        dn = 1;
        rready <= 0;
        rd = rdata;
        rs = rresp;
      end
    end
    to(dn);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    axr(a);
    chk("rdata", rd, {24'h0, e});
    chk("rresp", {30'h0, rs}, {30'h0, ok});
  endtask

  // second interval only: the first may be cut short by the unit change
  task automatic ticks(input logic [1:0] u, input int per);
    int n;
    axw(aPath, {u, 6'h00}, ok);
    repeat (2) @(posedge mclk);
    #1 chk("unitSel", {30'h0, shutterUnitSel}, {30'h0, u});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1 n++;
      end while (!unitTick && n < 1100);
    end
    if (per == 0) chk("tick", {31'h0, unitTick}, 0);
    else chk("period", n, per);
  endtask

  task automatic frame(input bit fvChk, input bit clr);
    int n;
    pixCnt = 0;
    @(posedge mclk);
    trig <= 1;
    @(posedge mclk);
    trig <= 0;
    n = 0;
    while (!frameValid && n < 20) begin
      @(posedge mclk);
      n++;
    end
    to(n < 20);
    repeat (3) @(posedge mclk);
    #1 chk("cc4", {31'h0, camCtrl[3]}, {31'h0, fvChk});
    if (clr) begin
      axw(aPath, 8'h00, ok);
      rchk(aPath, 8'h00);
      chk("midframe", {31'h0, frameValid}, 1);
    end
    n = 0;
    while (frameValid && n < 40) begin
      @(posedge mclk);
      n++;
    end
    to(n < 40);
    repeat (4) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    if (pixelOutValid) begin
      chk("pixel", {16'h0, pixelOut}, fullSel ? {16'h0, prevPix} :
          {24'h0, prevPix[15:8]});
      pixCnt++;
    end
    prevPix <= pixelIn;
  end

  initial begin
    #800000;
    chk("watchdog", 0, 1);
    stop_test;
  end

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 0;
    axw(aPath, 8'hFF, ok);
    rchk(aPath, 8'hD1);
    axw(aCam, 8'hFF, ok);
    rchk(aCam, 8'hFF);
    axw(8'h3C, 8'hFF, `RESP_SLVERR);
    axr(8'h3C);
    chk("unmapped", {rd[29:0], rs}, {30'h0, `RESP_SLVERR});
    $display("test registers done");
    for (int u = 0; u < 4; u++) ticks(u[1:0], u == 3 ? 0 : 10 * (10 ** u));
    $display("test units done");
    axw(aPath, 8'h10, ok);
    frame(0, 0);
    chk("nocapture", pixCnt, 0);
    axw(aCmd, 8'h02, ok);
    // continuous and go both set: expose routing live
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      cfg = {rtab[i % 7], seed[3:0]};
      axw(aCam, cfg, ok);
      shutterExpose <= seed[4];
      optoTrigger <= seed[5];
      repeat (3) @(posedge mclk);
      #1 chk("camCtrl", {28'h0, camCtrl},
             {28'h0, ccx(cfg, seed[4], seed[5])});
    end
    $display("test routing done");
    axw(aCam, 8'hC0, ok);
    axw(aPath, 8'h11, ok);
    fullSel = 1;
    frame(1, 0);
    chk("frame1", pixCnt, fl);
    axw(aPath, 8'h10, ok);
    fullSel = 0;
    frame(1, 0);
    chk("frame2", pixCnt, fl);
    frame(1, 1);
    chk("lastframe", pixCnt, fl);
    chk("idle", {31'h0, acquiring}, 0);
    chk("cc4 off", {31'h0, camCtrl[3]}, 0);
    rchk(aCmd, 8'h00);
    frame(0, 0);
    chk("stopped", pixCnt, 0);
    $display("test acquisition done");
    axw(aPath, 8'h10, ok);
    axw(aCmd, 8'h0A, ok);
    rchk(aPath, 8'h10);
    rchk(aStat, 8'h05);
    rchk(aCmd, 8'h0A);
    @(posedge mclk);
    dmaDone <= 1;
    @(posedge mclk);
    dmaDone <= 0;
    rchk(aPath, 8'h00);
    rchk(aStat, 8'h01);
    // no toggle pending: a completion must leave continuous alone
    axw(aPath, 8'h10, ok);
    @(posedge mclk);
    dmaDone <= 1;
    @(posedge mclk);
    dmaDone <= 0;
    rchk(aPath, 8'h10);
    $display("test deferred clear done");
    stop_test;
  end
endmodule
